// ---- rtl/circ_ctl.v ----
// circ_ctl.v: control-pin unit of an 8-bit processor core
// (ready stall, opcode fetch marker, interrupts, reset sequence, overflow set)
// assumes one bus cycle per core_clk cycle; pins synchronous to core_clk
`timescale 1ns/10ps
`include "circ_map.vh"

// Operation
// - ready stalls read cycles, never write cycles
// - stalled read keeps presenting its address
// - ready low on write ignored until read
// - maskable request waits for instruction end
// - maskable request taken only with mask clear
// - sequence pushes program counter and status
// - mask flag set after state saved
// - maskable vector low fffe, high ffff
// - interrupts recognised only while ready high
// - non-maskable request is a falling edge
// - non-maskable uses same sequence, ignores mask
// - non-maskable vector low fffa, high fffb
// - inputs sampled each cycle, start at boundary
// - external pin sets overflow flag
// - fetch marker high whole opcode fetch cycle
// - ready low in fetch freezes until high
// - writes suppressed while reset held low
// - reset rising edge starts sequence at once
// - six cycles, then mask set, vector fffc/fffd
module circ_ctl
(
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire        clk_en,
    // processor pins
    input  wire        rdy,
    input  wire        irq_n,
    input  wire        nmi_n,
    input  wire        so_n,
    input  wire        res_n,
    output wire        sync,
    // memory bus
    output wire [15:0] bus_addr,
    output wire [7:0]  bus_wdata,
    output wire        bus_we,
    input  wire [7:0]  bus_rdata,
    // core cycle request
    input  wire [15:0] core_req_addr,
    input  wire [7:0]  core_req_wdata,
    input  wire        core_req_we,
    input  wire        core_req_fetch,
    input  wire [7:0]  core_status,
    input  wire [7:0]  core_sp,
    input  wire        core_flag_i,
    // core answers
    output wire        core_take,
    output wire [7:0]  core_rdata,
    output wire        core_rvalid,
    output wire        core_reset,
    output wire        pc_load,
    output wire [15:0] pc_vec,
    output wire        sp_dec,
    output wire        set_i,
    output wire        set_v
);

// ----------------------------------------------------------------------
// states
// ----------------------------------------------------------------------
localparam [3:0] ST_IDLE   = 4'h0;
localparam [3:0] ST_PUSH_H = 4'h1;
localparam [3:0] ST_PUSH_L = 4'h2;
localparam [3:0] ST_PUSH_P = 4'h3;
localparam [3:0] ST_VEC_L  = 4'h4;
localparam [3:0] ST_VEC_H  = 4'h5;
localparam [3:0] ST_RESUME = 4'h6;
localparam [3:0] ST_RHOLD  = 4'h7;
localparam [3:0] ST_RINIT  = 4'h8;

// ----------------------------------------------------------------------
// state registers
// ----------------------------------------------------------------------
reg  [3:0]  state_q;
reg  [15:0] cyc_addr_q;
reg  [7:0]  cyc_wdata_q;
reg         cyc_we_q;
reg         cyc_fetch_q;
reg         cyc_core_q;
reg  [15:0] ret_q;
reg  [7:0]  sp_q;
reg  [1:0]  vsel_q;
reg  [`CIRC_RST_CNT_W-1:0] cnt_q;
reg  [7:0]  vec_lo_q;
reg  [15:0] pc_vec_q;
reg  [7:0]  rdata_q;
reg         rvalid_q;
reg         pc_load_q;
reg         sp_dec_q;
reg         set_i_q;
reg         set_v_q;
reg         irq_q;
reg         nmi_prev_q;
reg         nmi_pend_q;
reg         so_prev_q;
reg         res_prev_q;

// ----------------------------------------------------------------------
// next values
// ----------------------------------------------------------------------
reg  [3:0]  state_d;
reg         ld_d;
reg  [15:0] n_addr_d;
reg  [7:0]  n_wdata_d;
reg         n_we_d;
reg         n_fetch_d;
reg         n_core_d;
reg  [15:0] ret_d;
reg  [7:0]  sp_d;
reg  [1:0]  vsel_d;
reg  [`CIRC_RST_CNT_W-1:0] cnt_d;
reg         clr_nmi_d;
reg         set_i_d;
reg         sp_dec_d;
reg         pc_load_d;
reg  [15:0] vec_lo_addr;

// ----------------------------------------------------------------------
// cycle progress and recognition
// ----------------------------------------------------------------------
wire cyc_done  = cyc_we_q | rdy;
wire adv       = clk_en & cyc_done;
wire res_rise  = res_n & ~res_prev_q;
wire in_reset  = ~res_n | res_rise;
wire nmi_fall  = nmi_prev_q & ~nmi_n;
wire int_req   = nmi_pend_q | (irq_q & ~core_flag_i);
wire start_int = (state_q == ST_IDLE) & core_req_fetch & rdy & int_req;

always @*
begin
    case (vsel_q)
        `CIRC_VSEL_NMI: vec_lo_addr = `CIRC_VEC_NMI_LO;
        `CIRC_VSEL_RST: vec_lo_addr = `CIRC_VEC_RST_LO;
        default:        vec_lo_addr = `CIRC_VEC_IRQ_LO;
    endcase
end

// ----------------------------------------------------------------------
// sequencer
// ----------------------------------------------------------------------
always @*
begin
    state_d   = state_q;
    ld_d      = 1'b0;
    n_addr_d  = cyc_addr_q;
    n_wdata_d = `CIRC_RST_BYTE;
    n_we_d    = 1'b0;
    n_fetch_d = 1'b0;
    n_core_d  = 1'b0;
    ret_d     = ret_q;
    sp_d      = sp_q;
    vsel_d    = vsel_q;
    cnt_d     = cnt_q;
    clr_nmi_d = 1'b0;
    set_i_d   = 1'b0;
    sp_dec_d  = 1'b0;
    pc_load_d = 1'b0;
    if (!res_n)
    begin
        state_d  = ST_RHOLD;
        ld_d     = 1'b1;
        n_addr_d = core_req_addr;
    end
    else if (res_rise)
    begin
        state_d  = ST_RINIT;
        ld_d     = 1'b1;
        n_addr_d = core_req_addr;
        cnt_d    = `CIRC_RST_CNT;
    end
    else if (cyc_done)
    begin
        case (state_q)
            ST_IDLE, ST_RESUME:
            begin
                ld_d = 1'b1;
                if (start_int)
                begin
                    state_d   = ST_PUSH_H;
                    n_addr_d  = {`CIRC_STACK_PAGE, core_sp};
                    n_we_d    = 1'b1;
                    n_wdata_d = core_req_addr[`CIRC_PC_HI_MSB:`CIRC_PC_HI_LSB];
                    ret_d     = core_req_addr;
                    sp_d      = core_sp - 8'h01;
                    vsel_d    = nmi_pend_q ? `CIRC_VSEL_NMI : `CIRC_VSEL_IRQ;
                    clr_nmi_d = nmi_pend_q;
                end
                else
                begin
                    state_d   = ST_IDLE;
                    n_addr_d  = core_req_addr;
                    n_we_d    = core_req_we;
                    n_wdata_d = core_req_wdata;
                    n_fetch_d = core_req_fetch;
                    n_core_d  = 1'b1;
                end
            end
            ST_PUSH_H:
            begin
                state_d   = ST_PUSH_L;
                ld_d      = 1'b1;
                n_addr_d  = {`CIRC_STACK_PAGE, sp_q};
                n_we_d    = 1'b1;
                n_wdata_d = ret_q[`CIRC_PC_LO_MSB:`CIRC_PC_LO_LSB];
                sp_d      = sp_q - 8'h01;
                sp_dec_d  = 1'b1;
            end
            ST_PUSH_L:
            begin
                state_d   = ST_PUSH_P;
                ld_d      = 1'b1;
                n_addr_d  = {`CIRC_STACK_PAGE, sp_q};
                n_we_d    = 1'b1;
                n_wdata_d = core_status;
                sp_d      = sp_q - 8'h01;
                sp_dec_d  = 1'b1;
            end
            ST_PUSH_P:
            begin
                state_d  = ST_VEC_L;
                ld_d     = 1'b1;
                n_addr_d = vec_lo_addr;
                sp_dec_d = 1'b1;
                set_i_d  = 1'b1;
            end
            ST_VEC_L:
            begin
                state_d  = ST_VEC_H;
                ld_d     = 1'b1;
                n_addr_d = {vec_lo_addr[15:1], 1'b1};
            end
            ST_VEC_H:
            begin
                state_d   = ST_RESUME;
                ld_d      = 1'b1;
                n_addr_d  = cyc_addr_q;
                pc_load_d = 1'b1;
            end
            ST_RINIT:
            begin
                ld_d     = 1'b1;
                n_addr_d = core_req_addr;
                if (cnt_q == (`CIRC_RST_INIT_CYC - 3'h1))
                begin
                    state_d  = ST_VEC_L;
                    n_addr_d = `CIRC_VEC_RST_LO;
                    vsel_d   = `CIRC_VSEL_RST;
                    set_i_d  = 1'b1;
                end
                else
                begin
                    cnt_d = cnt_q + 3'h1;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end
end

// ----------------------------------------------------------------------
// registers
// ----------------------------------------------------------------------
always @(posedge core_clk)
begin
    if (!rst_n)
    begin
        state_q     <= ST_RHOLD;
        cyc_addr_q  <= `CIRC_RST_ADDR;
        cyc_wdata_q <= `CIRC_RST_BYTE;
        cyc_we_q    <= 1'b0;
        cyc_fetch_q <= 1'b0;
        cyc_core_q  <= 1'b0;
        ret_q       <= `CIRC_RST_ADDR;
        sp_q        <= `CIRC_RST_SP;
        vsel_q      <= `CIRC_VSEL_IRQ;
        cnt_q       <= `CIRC_RST_CNT;
        vec_lo_q    <= `CIRC_RST_BYTE;
        pc_vec_q    <= `CIRC_RST_ADDR;
        rdata_q     <= `CIRC_RST_BYTE;
        rvalid_q    <= 1'b0;
        pc_load_q   <= 1'b0;
        sp_dec_q    <= 1'b0;
        set_i_q     <= 1'b0;
        set_v_q     <= 1'b0;
        irq_q       <= 1'b0;
        nmi_prev_q  <= 1'b1;
        nmi_pend_q  <= 1'b0;
        so_prev_q   <= 1'b1;
        res_prev_q  <= 1'b0;
    end
    else if (clk_en)
    begin
        state_q    <= state_d;
        ret_q      <= ret_d;
        sp_q       <= sp_d;
        vsel_q     <= vsel_d;
        cnt_q      <= cnt_d;
        // stalled read keeps its address on the bus
        if (ld_d)
        begin
            cyc_addr_q  <= n_addr_d;
            cyc_wdata_q <= n_wdata_d;
            cyc_we_q    <= n_we_d;
            cyc_fetch_q <= n_fetch_d;
            cyc_core_q  <= n_core_d;
        end
        // vector capture
        if (adv && !in_reset && state_q == ST_VEC_L)
            vec_lo_q <= bus_rdata;
        if (adv && !in_reset && state_q == ST_VEC_H)
            pc_vec_q <= {bus_rdata, vec_lo_q};
        // core read data
        rvalid_q   <= adv & cyc_core_q & ~cyc_we_q;
        if (adv && cyc_core_q && !cyc_we_q)
            rdata_q <= bus_rdata;
        pc_load_q  <= pc_load_d;
        sp_dec_q   <= sp_dec_d;
        set_i_q    <= set_i_d;
        // pin sampling, one sample per cycle
        irq_q      <= ~irq_n;
        nmi_prev_q <= nmi_n;
        nmi_pend_q <= nmi_fall | (nmi_pend_q & ~clr_nmi_d);
        so_prev_q  <= so_n;
        set_v_q    <= so_prev_q & ~so_n;
        res_prev_q <= res_n;
    end
end

// ----------------------------------------------------------------------
// outputs
// ----------------------------------------------------------------------
assign sync        = cyc_fetch_q;
assign bus_addr    = cyc_addr_q;
assign bus_wdata   = cyc_wdata_q;
assign bus_we      = cyc_we_q & res_n;
assign core_take   = adv & ld_d & n_core_d;
assign core_rdata  = rdata_q;
assign core_rvalid = rvalid_q;
assign core_reset  = (state_q == ST_RHOLD) | (state_q == ST_RINIT);
assign pc_load     = pc_load_q;
assign pc_vec      = pc_vec_q;
assign sp_dec      = sp_dec_q;
assign set_i       = set_i_q;
assign set_v       = set_v_q;

endmodule // circ_ctl

// ---- rtl/circ_map.vh ----
// circ_map.vh: constants of the interrupt, reset and ready control unit
// assumes inclusion by bare name from the design file only
`ifndef CIRC_MAP_VH
`define CIRC_MAP_VH

// ----------------------------------------------------------------------
// vector locations
// ----------------------------------------------------------------------
`define CIRC_VEC_NMI_LO   16'hfffa
`define CIRC_VEC_RST_LO   16'hfffc
`define CIRC_VEC_IRQ_LO   16'hfffe

// ----------------------------------------------------------------------
// vector selector codes
// ----------------------------------------------------------------------
`define CIRC_VSEL_IRQ     2'h0
`define CIRC_VSEL_NMI     2'h1
`define CIRC_VSEL_RST     2'h2

// ----------------------------------------------------------------------
// stack page and field positions
// ----------------------------------------------------------------------
`define CIRC_STACK_PAGE   8'h01
`define CIRC_PC_HI_MSB    15
`define CIRC_PC_HI_LSB    8
`define CIRC_PC_LO_MSB    7
`define CIRC_PC_LO_LSB    0

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define CIRC_RST_INIT_CYC 3'h6
`define CIRC_RST_CNT_W    3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CIRC_RST_ADDR     16'h0000
`define CIRC_RST_BYTE     8'h00
`define CIRC_RST_SP       8'h00
`define CIRC_RST_CNT      3'h0

`endif

// ---- testbench/circ_ctl_assertions.sv ----
// circ_ctl_assertions.sv: port timing checks of the control-pin unit
// assumes a bind into circ_ctl, one clock domain
`timescale 1ns/10ps
module circ_ctl_assertions
(
    // clock and reset
    input logic        core_clk,
    input logic        rst_n,
    input logic        clk_en,
    // pins and bus
    input logic        rdy,
    input logic        so_n,
    input logic        res_n,
    input logic        sync,
    input logic [15:0] bus_addr,
    input logic        bus_we,
    // core side
    input logic [15:0] core_req_addr,
    input logic        core_req_we,
    input logic        core_req_fetch,
    input logic        core_take,
    input logic        core_reset,
    input logic        pc_load,
    input logic        sp_dec,
    input logic        set_i,
    input logic        set_v
);
// --------
// checks
// --------
default clocking cb @(posedge core_clk); endclocking
default disable iff (!rst_n);
stall_hold_a : assert property (
    clk_en && res_n && !core_reset && !bus_we && !rdy |=> $stable(bus_addr) && $stable(sync))
    else $error("stalled read lost its address");
stall_no_take_a : assert property (!bus_we && !rdy |-> !core_take)
    else $error("read ended while not ready");
write_pass_a : assert property (
    clk_en && bus_we && !rdy
    |=> !bus_we || bus_addr != $past(bus_addr) || $past(core_take))
    else $error("write cycle was stalled");
no_write_reset_a : assert property (!res_n |-> !bus_we)
    else $error("write while reset pin low");
vec_pair_a : assert property (
    bus_addr >= 16'hfffa && !bus_addr[0] && !bus_we && rdy && res_n
    |=> bus_addr == $past(bus_addr) + 16'h1) else $error("vector high byte not next");
reset_start_a : assert property ($rose(res_n) |-> ##[6:40] bus_addr == 16'hfffc)
    else $error("reset vector not fetched in time");
fetch_mark_a : assert property (
    core_take && res_n && !core_reset
    |=> bus_addr == $past(core_req_addr) && sync == $past(core_req_fetch))
    else $error("fetch marker wrong");
push_count_a : assert property (
    sp_dec |-> $past(bus_we) && $past(bus_addr[15:8]) == 8'h01)
    else $error("stack step without a push");
mask_set_a : assert property (
    set_i |-> !bus_we && bus_addr inside {16'hfffa, 16'hfffc, 16'hfffe})
    else $error("mask set outside vector read");
overflow_set_a : assert property ($past(so_n) && !so_n |-> ##[1:3] set_v)
    else $error("overflow set missing");
cover property (pc_load);
cover property (set_v);
cover property (sync && !rdy);
endmodule // circ_ctl_assertions

// ---- testbench/circ_ctl_tb_top.sv ----
// circ_ctl_tb_top.sv: self-checking bench of the control-pin unit
// assumes circ_ctl, circ_far and the checker are compiled first
`timescale 1ns/10ps
module circ_ctl_tb_top;
logic        core_clk, rst_n, clk_en, irq_n, nmi_n, so_n, stall, res_req, flag;
logic        rdy, res_n, sync, bus_we, take, rv, creset, pc_load, sp_dec, set_i, set_v;
logic        r_we, r_fetch;
logic [15:0] bus_addr, pc_vec, r_addr, exp_lo, pa;
logic [7:0]  wdata, rdata, crdata, r_wdata, st, sp;
logic [23:0] w0, w1, w2;
logic [31:0] rnd;
int          bad_count, checked, n_load, n_setv, n0, k;
// --------
// helpers
// --------
function [31:0] xs(input [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
endfunction
function [7:0] mem(input [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
endfunction
task check(input [23:0] seen, input [23:0] exp);
    checked++;
    if (seen !== exp)
    begin
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        bad_count++;
    end
endtask
task test_done;
    if (bad_count == 0 && checked > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
task wait_load(input [15:0] lo);
    int i;
    exp_lo = lo;
    n0 = n_load;
    for (i = 0; i < 300 && n_load == n0; i++)
        @(posedge core_clk);
    check({23'h0, n_load != n0}, 24'h1);
endtask
// --------
// units
// --------
circ_ctl dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .rdy(rdy), .irq_n(irq_n),
    .nmi_n(nmi_n), .so_n(so_n), .res_n(res_n), .sync(sync), .bus_addr(bus_addr),
    .bus_wdata(wdata), .bus_we(bus_we), .bus_rdata(rdata), .core_req_addr(r_addr),
    .core_req_wdata(r_wdata), .core_req_we(r_we), .core_req_fetch(r_fetch),
    .core_status(st), .core_sp(sp), .core_flag_i(flag), .core_take(take),
    .core_rdata(crdata), .core_rvalid(rv), .core_reset(creset), .pc_load(pc_load),
    .pc_vec(pc_vec), .sp_dec(sp_dec), .set_i(set_i), .set_v(set_v));
circ_far far (.core_clk(core_clk), .rst_n(rst_n), .stall(stall), .res_req(res_req),
    .bus_addr(bus_addr), .bus_we(bus_we), .rdy(rdy), .res_n(res_n), .bus_rdata(rdata));
// --------
// core model and monitors
// --------
always @(posedge core_clk)
begin
    rnd <= xs(rnd);
    stall <= (rnd[2:0] == 3'h0);
    pa <= bus_addr;
    if (rv)
        check({16'h0, crdata}, {16'h0, mem(pa)});
    if (set_i)
        flag <= 1'b1;
    if (take)
    begin
        r_addr <= {1'b0, rnd[30:16]};
        r_we <= rnd[4];
        r_fetch <= rnd[5] & !rnd[4];
        r_wdata <= rnd[15:8];
        st <= rnd[23:16];
        sp <= rnd[31:24];
    end
    if (bus_we)
        {w2, w1, w0} <= {w1, w0, bus_addr, wdata};
    if (set_v)
        n_setv++;
    if (pc_load)
    begin
        n_load++;
        check({8'h0, pc_vec}, {8'h0, mem(exp_lo + 16'h1), mem(exp_lo)});
        if (exp_lo != 16'hfffc)
        begin
            check(w2, {8'h01, sp, r_addr[15:8]});
            check(w1, {8'h01, sp - 8'h1, r_addr[7:0]});
            check(w0, {8'h01, sp - 8'h2, st});
        end
    end
end
// --------
// sequence
// --------
initial
begin
    core_clk = 1'b0;
    forever
        #50 core_clk = ~core_clk;
end
initial
begin
    #(100 * 5000);
    bad_count++;
    test_done;
end
initial
begin
    {rst_n, stall, res_req, r_we, r_wdata, st, w0, w1, w2} = '0;
    {clk_en, irq_n, nmi_n, so_n, flag, r_fetch} = 6'h3f;
    {bad_count, checked, n_load, n_setv} = '0;
    rnd = 32'hc1f6;
    r_addr = 16'h0100;
    sp = 8'hff;
    exp_lo = 16'hfffc;
    repeat (8)
        @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    check({23'h0, creset}, 24'h1);
    wait_load(16'hfffc);
    check({23'h0, creset}, 24'h0);
    for (k = 0; k < 6; k++)
    begin
        @(posedge core_clk);
        if (k % 3 == 0)
        begin
            flag <= 1'b0;
            irq_n <= 1'b0;
        end
        nmi_n <= (k % 3 != 1);
        res_req <= (k % 3 == 2);
        @(posedge core_clk);
        nmi_n <= 1'b1;
        res_req <= 1'b0;
        wait_load(k % 3 == 0 ? 16'hfffe : k % 3 == 1 ? 16'hfffa : 16'hfffc);
        irq_n <= 1'b1;
    end
    n0 = n_load;
    irq_n <= 1'b0;
    repeat (40)
        @(posedge core_clk);
    check(n_load[23:0], n0[23:0]);
    irq_n <= 1'b1;
    so_n <= 1'b0;
    repeat (6)
        @(posedge core_clk);
    so_n <= 1'b1;
    repeat (4)
        @(posedge core_clk);
    check(n_setv[23:0], 24'h1);
    test_done;
end
endmodule // circ_ctl_tb_top
bind circ_ctl circ_ctl_assertions chk (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .rdy(rdy), .so_n(so_n), .res_n(res_n), .sync(sync), .bus_addr(bus_addr), .bus_we(bus_we),
    .core_req_addr(core_req_addr), .core_req_we(core_req_we), .core_req_fetch(core_req_fetch),
    .core_take(core_take), .core_reset(core_reset), .pc_load(pc_load), .sp_dec(sp_dec),
    .set_i(set_i), .set_v(set_v));

// ---- testbench/circ_far.sv ----
// circ_far.sv: memory, wait-state and reset circuitry beside the unit
// assumes stall and res_req from the bench, driven at the rising edge
`timescale 1ns/10ps
module circ_far
(
    // clock and control
    input  logic        core_clk,
    input  logic        rst_n,
    input  logic        stall,
    input  logic        res_req,
    // bus and pins
    input  logic [15:0] bus_addr,
    input  logic        bus_we,
    output logic        rdy,
    output logic        res_n,
    output logic [7:0]  bus_rdata
);
logic [1:0] cnt_q;
always @(posedge core_clk)
    if (!rst_n || res_req)
        cnt_q <= 2'h3;
    else if (cnt_q != 2'h0)
        cnt_q <= cnt_q - 2'h1;
assign res_n = (cnt_q == 2'h0);
assign rdy = !stall;
assign bus_rdata = bus_we ? ~bus_addr[7:0] : bus_addr[7:0] ^ bus_addr[15:8] ^ 8'h5a;
endmodule // circ_far
